// ===== logic/qcrb_pkg.sv
/*
 qcrb_pkg: offsets, field positions and bus carriers for the four-channel
 register bank. assumes 8-bit host data and 7-bit register offsets.
*/
package qcrb_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int NUM_CH = 4;
   localparam int CH_W   = 2;
   localparam int PC_W   = 5;   // per-channel slot index width

   typedef logic [ADDR_W-1:0] qcrb_addr_t;
   typedef logic [DATA_W-1:0] qcrb_data_t;
   typedef logic [CH_W-1:0]   qcrb_ch_t;
   typedef logic [PC_W-1:0]   qcrb_slot_t;

   // global registers
   localparam qcrb_addr_t OFS_FIRMWARE_REVISION = 7'h40;
   localparam qcrb_addr_t OFS_RECEIVE_IRQ_CH    = 7'h44;
   localparam qcrb_addr_t OFS_TRANSMIT_IRQ_CH   = 7'h45;
   localparam qcrb_addr_t OFS_MODEM_IRQ_CH      = 7'h46;
   localparam qcrb_addr_t OFS_GLOBAL_CONFIG     = 7'h4b;
   localparam qcrb_addr_t OFS_SERVICE_SUMMARY   = 7'h67;
   localparam qcrb_addr_t OFS_CHANNEL_SELECT    = 7'h68;
   localparam qcrb_addr_t OFS_MODEM_IRQ_REQ     = 7'h69;
   localparam qcrb_addr_t OFS_TRANSMIT_IRQ_REQ  = 7'h6a;
   localparam qcrb_addr_t OFS_RECEIVE_IRQ_REQ   = 7'h6b;
   localparam qcrb_addr_t OFS_PRESCALER_PERIOD  = 7'h7e;
   // virtual registers
   localparam qcrb_addr_t OFS_MODEM_IRQ_VECTOR  = 7'h41;
   localparam qcrb_addr_t OFS_TRANSMIT_IRQ_VEC  = 7'h42;
   localparam qcrb_addr_t OFS_RECEIVE_IRQ_VEC   = 7'h43;
   localparam qcrb_addr_t OFS_MODEM_IRQ_STATUS  = 7'h4c;
   localparam qcrb_addr_t OFS_END_OF_SERVICE    = 7'h60;
   localparam qcrb_addr_t OFS_RECEIVE_DATA_STAT = 7'h62;
   localparam qcrb_addr_t OFS_TRANSMIT_DATA     = 7'h63;
   // per-channel registers
   localparam qcrb_addr_t OFS_CHANNEL_COMMAND   = 7'h05;
   localparam qcrb_addr_t OFS_SERVICE_REQ_EN    = 7'h06;
   localparam qcrb_addr_t OFS_CHANNEL_OPTION_1  = 7'h08;
   localparam qcrb_addr_t OFS_CHANNEL_OPTION_2  = 7'h09;
   localparam qcrb_addr_t OFS_CHANNEL_OPTION_3  = 7'h0a;
   localparam qcrb_addr_t OFS_CHANNEL_CTRL_STAT = 7'h0b;
   localparam qcrb_addr_t OFS_RECEIVED_COUNT    = 7'h0e;
   localparam qcrb_addr_t OFS_MODEM_CHANGE_1    = 7'h15;
   localparam qcrb_addr_t OFS_MODEM_CHANGE_2    = 7'h16;
   localparam qcrb_addr_t OFS_LOCAL_IRQ_VECTOR  = 7'h18;
   localparam qcrb_addr_t OFS_SPECIAL_CHAR_1    = 7'h1a;
   localparam qcrb_addr_t OFS_SPECIAL_CHAR_2    = 7'h1b;
   localparam qcrb_addr_t OFS_SPECIAL_CHAR_3    = 7'h1c;
   localparam qcrb_addr_t OFS_SPECIAL_CHAR_4    = 7'h1d;
   localparam qcrb_addr_t OFS_CHANNEL_OPTION_4  = 7'h1e;
   localparam qcrb_addr_t OFS_CHANNEL_OPTION_5  = 7'h1f;
   localparam qcrb_addr_t OFS_RX_TIMEOUT_PERIOD = 7'h21;
   localparam qcrb_addr_t OFS_SPECIAL_RANGE_LO  = 7'h22;
   localparam qcrb_addr_t OFS_SPECIAL_RANGE_HI  = 7'h23;
   localparam qcrb_addr_t OFS_LITERAL_NEXT_CHAR = 7'h24;
   localparam qcrb_addr_t OFS_MODEM_SIGNAL_1    = 7'h6c;
   localparam qcrb_addr_t OFS_MODEM_SIGNAL_2    = 7'h6d;
   localparam qcrb_addr_t OFS_PRINTER_SIGNAL    = 7'h6f;
   localparam qcrb_addr_t OFS_TX_BIT_PERIOD     = 7'h72;
   localparam qcrb_addr_t OFS_TX_CLOCK_OPTION   = 7'h76;
   localparam qcrb_addr_t OFS_RX_BIT_PERIOD     = 7'h78;
   localparam qcrb_addr_t OFS_RX_CLOCK_OPTION   = 7'h7c;

   // field layouts
   localparam int         CHSEL_LSB      = 0;    // channel number in channel_select
   localparam int         GCFG_PAR_BIT   = 7;    // channel 0 parallel mode
   localparam qcrb_data_t RESET_BYTE     = 8'h00;
   localparam qcrb_ch_t   RESET_CHANNEL  = 2'h0;
   localparam qcrb_data_t VIRT_IDLE_BYTE = 8'h00;

   // host i/o cycle, one-cycle strobes
   typedef struct packed {
      logic       rd;
      logic       wr;
      qcrb_addr_t addr;
      qcrb_data_t wdata;
   } qcrb_req_s;

   // datapath-facing status carrier
   typedef struct packed {
      qcrb_data_t rx_vector;
      qcrb_data_t tx_vector;
      qcrb_data_t modem_vector;
      qcrb_data_t rx_data;
      qcrb_data_t modem_status;
      qcrb_data_t summary;
   } qcrb_virt_s;
endpackage : qcrb_pkg

// ===== logic/qcrb_bank_mem.sv
/*
 qcrb_bank_mem: storage for the four per-channel register copies.
 assumes one write port and one read port, both usable in the same cycle; read data registered.
*/
`timescale 1ns/100ps
`default_nettype none
module qcrb_bank_mem #(
   parameter int DEPTH = 128,
   parameter int AW    = 7,
   parameter int DW    = 8
) (
   // clock
   input  wire logic          clk,
   // access
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output var  logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [DEPTH];

   // no reset on the array: contents undefined until software writes them
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : qcrb_bank_mem
`default_nettype wire

// ===== logic/qcrb_global_regs.sv
/*
 qcrb_global_regs: always-reachable global control registers.
 assumes write strobe already qualified by the global decode.
*/
`timescale 1ns/100ps
`default_nettype none
module qcrb_global_regs
   import qcrb_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // write side
   input  wire logic             wr,
   input  wire qcrb_pkg::qcrb_addr_t addr,
   input  wire qcrb_pkg::qcrb_data_t wdata,
   // register values
   output var  qcrb_pkg::qcrb_data_t firmware_q,
   output var  qcrb_pkg::qcrb_data_t gcfg_q,
   output var  qcrb_pkg::qcrb_data_t prescale_q,
   output var  qcrb_pkg::qcrb_data_t rx_ch_q,
   output var  qcrb_pkg::qcrb_data_t tx_ch_q,
   output var  qcrb_pkg::qcrb_data_t md_ch_q,
   output var  qcrb_pkg::qcrb_data_t rx_req_q,
   output var  qcrb_pkg::qcrb_data_t tx_req_q,
   output var  qcrb_pkg::qcrb_data_t md_req_q
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         firmware_q <= RESET_BYTE;
         gcfg_q     <= RESET_BYTE;
         prescale_q <= RESET_BYTE;
         rx_ch_q    <= RESET_BYTE;
         tx_ch_q    <= RESET_BYTE;
         md_ch_q    <= RESET_BYTE;
         rx_req_q   <= RESET_BYTE;
         tx_req_q   <= RESET_BYTE;
         md_req_q   <= RESET_BYTE;
      end else if (wr) begin
         unique case (addr)
            OFS_FIRMWARE_REVISION: firmware_q <= wdata;
            OFS_GLOBAL_CONFIG:     gcfg_q     <= wdata;
            OFS_PRESCALER_PERIOD:  prescale_q <= wdata;
            OFS_RECEIVE_IRQ_CH:    rx_ch_q    <= wdata;
            OFS_TRANSMIT_IRQ_CH:   tx_ch_q    <= wdata;
            OFS_MODEM_IRQ_CH:      md_ch_q    <= wdata;
            OFS_RECEIVE_IRQ_REQ:   rx_req_q   <= wdata;
            OFS_TRANSMIT_IRQ_REQ:  tx_req_q   <= wdata;
            OFS_MODEM_IRQ_REQ:     md_req_q   <= wdata;
            default: ;
         endcase
      end
   end
endmodule : qcrb_global_regs
`default_nettype wire

// ===== logic/qcrb_bank.sv
/*
 qcrb_bank: host register file and decoder for the four-channel controller.
 assumes the host drives a one-cycle rd or wr strobe with a 7-bit offset,
 synchronous to clk; the datapath supplies virtual contents and the
 service-context flag.
 per-channel storage is not reset: software fills a bank before reading it.
 transmit and end-of-service writes are dropped outside a service routine.
*/
// Notes on behaviour
// - global offsets decode independent of selected bank
// - virtual registers valid only during service context
// - four separate copies of per-channel registers
// - channel_select write picks bank zero to three
// - only one channel bank visible at once
// - bank selection persists until channel_select rewritten
// - seven offset bits select at most one register; unmapped offsets select none
// - channel 0 dual registers follow serial/parallel mode
// - channels 1-3 always use serial meaning
`timescale 1ns/100ps
`default_nettype none
module qcrb_bank
   import qcrb_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // host i/o cycle
   input  wire qcrb_pkg::qcrb_req_s  host_req,
   output logic [7:0]                rdata,
   output logic                      rvalid,
   // datapath side
   input  wire logic                 service_active,
   input  wire qcrb_pkg::qcrb_virt_s virt_in,
   output logic [1:0]                sel_channel,
   output logic                      ch_dual_parallel,
   output logic                      tx_data_stb,
   output logic [7:0]                tx_data,
   output logic                      end_service_stb
);
   import qcrb_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // decode

   // true for an offset held in the per-channel banks
   function automatic logic is_per_channel(input qcrb_addr_t a);
      unique case (a)
         OFS_CHANNEL_COMMAND,
         OFS_SERVICE_REQ_EN,
         OFS_CHANNEL_OPTION_1,
         OFS_CHANNEL_OPTION_2,
         OFS_CHANNEL_OPTION_3,
         OFS_CHANNEL_CTRL_STAT,
         OFS_RECEIVED_COUNT,
         OFS_MODEM_CHANGE_1,
         OFS_MODEM_CHANGE_2,
         OFS_LOCAL_IRQ_VECTOR,
         OFS_SPECIAL_CHAR_1,
         OFS_SPECIAL_CHAR_2,
         OFS_SPECIAL_CHAR_3,
         OFS_SPECIAL_CHAR_4,
         OFS_CHANNEL_OPTION_4,
         OFS_CHANNEL_OPTION_5,
         OFS_RX_TIMEOUT_PERIOD,
         OFS_SPECIAL_RANGE_LO,
         OFS_SPECIAL_RANGE_HI,
         OFS_LITERAL_NEXT_CHAR,
         OFS_MODEM_SIGNAL_1,
         OFS_MODEM_SIGNAL_2,
         OFS_PRINTER_SIGNAL,
         OFS_TX_BIT_PERIOD,
         OFS_TX_CLOCK_OPTION,
         OFS_RX_BIT_PERIOD,
         OFS_RX_CLOCK_OPTION:
            return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : is_per_channel

   // read-only per-channel offsets: writes ignored
   function automatic logic is_pc_readonly(input qcrb_addr_t a);
      return (a == OFS_CHANNEL_CTRL_STAT) || (a == OFS_RECEIVED_COUNT);
   endfunction : is_pc_readonly

   // registers with a parallel meaning on channel 0
   function automatic logic is_dual(input qcrb_addr_t a);
      return (a == OFS_PRINTER_SIGNAL) ||
             (a == OFS_MODEM_SIGNAL_1) ||
             (a == OFS_MODEM_SIGNAL_2) ||
             (a == OFS_CHANNEL_OPTION_1);
   endfunction : is_dual

   // bank index sits above the 7-bit offset in the storage address
   localparam int MEM_AW    = CH_W + ADDR_W;
   localparam int MEM_DEPTH = NUM_CH << ADDR_W;

   qcrb_ch_t   chsel_q;
   qcrb_data_t firmware_q;
   qcrb_data_t gcfg_q;
   qcrb_data_t prescale_q;
   qcrb_data_t rx_ch_q;
   qcrb_data_t tx_ch_q;
   qcrb_data_t md_ch_q;
   qcrb_data_t rx_req_q;
   qcrb_data_t tx_req_q;
   qcrb_data_t md_req_q;

   wire qcrb_addr_t a        = host_req.addr;
   wire logic       pc_hit   = is_per_channel(a);
   wire logic       pc_wr    = host_req.wr && pc_hit && !is_pc_readonly(a);
   wire logic       sel_wr   = host_req.wr && (a == OFS_CHANNEL_SELECT);
   // global decode never looks at chsel_q
   wire logic       glob_wr  = host_req.wr && !pc_hit;
   // bank index: channel number above the 7-bit offset, one bank per access
   wire logic [MEM_AW-1:0] mem_addr = {chsel_q, a};
   wire logic       parallel = gcfg_q[GCFG_PAR_BIT];
   // the datapath owns the service flag; no context tracking here
   wire logic       virt_ok  = service_active;

   ////////////////////////////////////////////////////////////////////
   // storage

   // array left unreset: a reset tree over four banks outweighs the decoder
   qcrb_data_t mem_rdata;
   qcrb_bank_mem #(.DEPTH(MEM_DEPTH), .AW(MEM_AW), .DW(DATA_W)) u_mem (
      .clk   (clk),
      .we    (pc_wr),
      .waddr (mem_addr),
      .wdata (host_req.wdata),
      .raddr (mem_addr),
      .rdata (mem_rdata)
   );

   qcrb_global_regs u_glob (
      .clk        (clk),
      .rst_n      (rst_n),
      .wr         (glob_wr),
      .addr       (a),
      .wdata      (host_req.wdata),
      .firmware_q (firmware_q),
      .gcfg_q     (gcfg_q),
      .prescale_q (prescale_q),
      .rx_ch_q    (rx_ch_q),
      .tx_ch_q    (tx_ch_q),
      .md_ch_q    (md_ch_q),
      .rx_req_q   (rx_req_q),
      .tx_req_q   (tx_req_q),
      .md_req_q   (md_req_q)
   );

   ////////////////////////////////////////////////////////////////////
   // channel select

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chsel_q <= RESET_CHANNEL;
      end else if (sel_wr) begin
         chsel_q <= host_req.wdata[CHSEL_LSB +: CH_W];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read path: global and virtual answers one cycle after the strobe,
   // aligned with the bank memory's registered data

   logic       rd_q, rd_pc_q;
   qcrb_data_t rd_glob_q;
   qcrb_data_t glob_mux;

   // virtual contents masked outside a service routine
   always_comb begin
      unique case (a)
         OFS_FIRMWARE_REVISION: glob_mux = firmware_q;
         OFS_CHANNEL_SELECT:    glob_mux = {{(DATA_W-CH_W){1'b0}}, chsel_q};
         OFS_GLOBAL_CONFIG:     glob_mux = gcfg_q;
         OFS_SERVICE_SUMMARY:   glob_mux = virt_in.summary;
         OFS_RECEIVE_IRQ_CH:    glob_mux = rx_ch_q;
         OFS_TRANSMIT_IRQ_CH:   glob_mux = tx_ch_q;
         OFS_MODEM_IRQ_CH:      glob_mux = md_ch_q;
         OFS_RECEIVE_IRQ_REQ:   glob_mux = rx_req_q;
         OFS_TRANSMIT_IRQ_REQ:  glob_mux = tx_req_q;
         OFS_MODEM_IRQ_REQ:     glob_mux = md_req_q;
         OFS_PRESCALER_PERIOD:  glob_mux = prescale_q;
         OFS_RECEIVE_IRQ_VEC:   glob_mux = virt_ok ? virt_in.rx_vector : VIRT_IDLE_BYTE;
         OFS_TRANSMIT_IRQ_VEC:  glob_mux = virt_ok ? virt_in.tx_vector : VIRT_IDLE_BYTE;
         OFS_MODEM_IRQ_VECTOR:  glob_mux = virt_ok ? virt_in.modem_vector : VIRT_IDLE_BYTE;
         OFS_RECEIVE_DATA_STAT: glob_mux = virt_ok ? virt_in.rx_data : VIRT_IDLE_BYTE;
         OFS_MODEM_IRQ_STATUS:  glob_mux = virt_ok ? virt_in.modem_status : VIRT_IDLE_BYTE;
         default:               glob_mux = RESET_BYTE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q      <= 1'b0;
         rd_pc_q   <= 1'b0;
         rd_glob_q <= RESET_BYTE;
      end else begin
         rd_q      <= host_req.rd;
         rd_pc_q   <= host_req.rd && pc_hit;
         rd_glob_q <= glob_mux;
      end
   end

   // zero between answers, so a stale byte never passes for a fresh one
   wire qcrb_data_t rd_next = rd_pc_q ? mem_rdata : rd_glob_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata  <= RESET_BYTE;
         rvalid <= 1'b0;
      end else begin
         rdata  <= rd_q ? rd_next : RESET_BYTE;
         rvalid <= rd_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // datapath strobes and mode

   // tx data and end-of-service are virtual: dropped outside service
   wire logic txd_wr = host_req.wr && virt_ok && (a == OFS_TRANSMIT_DATA);
   wire logic eos_wr = host_req.wr && virt_ok && (a == OFS_END_OF_SERVICE);
   // parallel meaning only for channel 0; others stay serial
   wire logic dual_par = parallel && (chsel_q == RESET_CHANNEL);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_channel      <= RESET_CHANNEL;
         ch_dual_parallel <= 1'b0;
         tx_data_stb      <= 1'b0;
         tx_data          <= RESET_BYTE;
         end_service_stb  <= 1'b0;
      end else begin
         sel_channel      <= chsel_q;
         ch_dual_parallel <= dual_par;
         tx_data_stb      <= txd_wr;
         tx_data          <= txd_wr ? host_req.wdata : tx_data;
         end_service_stb  <= eos_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   a_sel_reset_ch0: assert property (@(posedge clk)
      $rose(rst_n) |-> chsel_q == RESET_CHANNEL)
      else $error("bank not channel 0 after reset");

   a_sel_write_takes: assert property (@(posedge clk) disable iff (!rst_n)
      sel_wr |=> chsel_q == $past(host_req.wdata[CHSEL_LSB +: CH_W]))
      else $error("channel select write not taken");

   a_sel_holds: assert property (@(posedge clk) disable iff (!rst_n)
      !sel_wr |=> $stable(chsel_q))
      else $error("bank changed without select write");

   a_sel_visible: assert property (@(posedge clk) disable iff (!rst_n)
      sel_wr
      |-> ##2 sel_channel == $past(host_req.wdata[CHSEL_LSB +: CH_W], 2))
      else $error("selected bank not shown on output");

   a_sel_readback: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.rd && a == OFS_CHANNEL_SELECT
      |-> ##2 rdata == {{(DATA_W-CH_W){1'b0}}, $past(chsel_q, 2)})
      else $error("channel select readback wrong");

   a_read_latency: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.rd |-> ##2 rvalid)
      else $error("read answer not two cycles later");

   a_rvalid_single: assert property (@(posedge clk) disable iff (!rst_n)
      rvalid && !$past(host_req.rd) |=> !rvalid)
      else $error("read answer stood too long");

   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !rvalid |-> rdata == RESET_BYTE)
      else $error("read data not zero between answers");

   a_global_indep: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.rd && a == OFS_GLOBAL_CONFIG |-> ##2 rdata == $past(gcfg_q, 2))
      else $error("global read wrong");

   a_glob_firmware: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.rd && a == OFS_FIRMWARE_REVISION
      |-> ##2 rdata == $past(firmware_q, 2))
      else $error("firmware revision read wrong");

   a_virt_masked: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.rd && !service_active && a == OFS_RECEIVE_DATA_STAT
      |-> ##2 rdata == VIRT_IDLE_BYTE)
      else $error("virtual visible outside service");

   a_virt_live: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.rd && service_active && a == OFS_RECEIVE_IRQ_VEC
      |-> ##2 rdata == $past(virt_in.rx_vector, 2))
      else $error("virtual vector hidden in service");

   a_txd_taken: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.wr && service_active && a == OFS_TRANSMIT_DATA
      |=> tx_data_stb && tx_data == $past(host_req.wdata))
      else $error("transmit byte not passed on");

   a_eos_taken: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.wr && service_active && a == OFS_END_OF_SERVICE
      |=> end_service_stb)
      else $error("end of service not signalled");

   a_strobe_masked: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.wr && !service_active
      |=> !tx_data_stb && !end_service_stb)
      else $error("virtual write taken outside service");

   a_one_bank_write: assert property (@(posedge clk) disable iff (!rst_n)
      pc_wr |-> mem_addr[MEM_AW-1 -: CH_W] == chsel_q && !glob_wr)
      else $error("per-channel write not one bank");

   a_dual_serial: assert property (@(posedge clk) disable iff (!rst_n)
      chsel_q != RESET_CHANNEL |=> !ch_dual_parallel)
      else $error("channel 1-3 in parallel meaning");

   a_dual_write_serial: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.wr && is_dual(a) && chsel_q != RESET_CHANNEL
      |=> !ch_dual_parallel)
      else $error("dual register parallel off channel 0");

   a_dual_ch0: assert property (@(posedge clk) disable iff (!rst_n)
      chsel_q == RESET_CHANNEL |=> ch_dual_parallel == $past(parallel))
      else $error("channel 0 mode not followed");

   a_dual_write_ch0: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.wr && is_dual(a) && chsel_q == RESET_CHANNEL
      |=> ch_dual_parallel == $past(parallel))
      else $error("channel 0 dual meaning lost");

   a_copies_apart: assert property (@(posedge clk) disable iff (!rst_n)
      pc_wr |-> mem_addr[ADDR_W-1:0] == a)
      else $error("bank offset mangled");
endmodule : qcrb_bank
`default_nettype wire

// ===== dv/qcrb_host.sv
/*
 qcrb_host: host processor model driving the register bank's i/o cycles.
 assumes the bench calls access() and that the host sits on one byte lane.
*/
`timescale 1ns/100ps
`default_nettype none
module qcrb_host
   import qcrb_pkg::*;
#(
   parameter int LANE_SHIFT = 1,
   parameter bit BIG_END    = 1
) (
   // clock
   input  wire logic                clk,
   // bus
   output var  qcrb_pkg::qcrb_req_s host_req
);
   initial host_req = '0;

   ////////////////////////////////////////////////////////////////////////////////
   // programmer address shifted for the lane, wiring picks the offset back out
   function automatic qcrb_addr_t lane(input qcrb_addr_t ofs);
      logic [15:0] ha;
      ha = (16'(ofs) << LANE_SHIFT) | 16'(BIG_END);
      return ha[LANE_SHIFT +: ADDR_W];
   endfunction : lane

   // one strobe cycle; released lines show the inverse so stale data never matches
   task automatic access(input logic is_rd, input qcrb_addr_t ofs, input qcrb_data_t d);
      @(negedge clk);
      host_req.rd    <= is_rd;
      host_req.wr    <= !is_rd;
      host_req.addr  <= lane(ofs);
      host_req.wdata <= d;
      @(negedge clk);
      host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~lane(ofs), wdata: ~d};
   endtask : access
endmodule : qcrb_host
`default_nettype wire

// ===== dv/tb_qcrb_bank.sv
/*
 tb_qcrb_bank: self-checking bench for the register bank.
 assumes qcrb_host drives the bus; reads expect rvalid two cycles later.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_qcrb_bank;
   import qcrb_pkg::*;
   logic       clk;
   logic       rst_n;
   logic       service_active;
   qcrb_virt_s virt_in;
   qcrb_req_s  host_req;
   logic [7:0] rdata;
   logic       rvalid;
   logic [1:0] sel_channel;
   logic       ch_dual_parallel;
   logic       tx_data_stb;
   logic [7:0] tx_data;
   logic       end_service_stb;
   int         bad_count = 0;
   int         n_checks  = 0;
   int         cyc       = 0;
   int         es_exp    = 0;
   int         es_seen   = 0;
   qcrb_data_t rd_q[$];
   qcrb_data_t tx_q[$];
   qcrb_data_t v[4][3];
   qcrb_data_t g[4];
   qcrb_addr_t pc_ofs[3] = '{OFS_CHANNEL_OPTION_1, OFS_SPECIAL_CHAR_1, OFS_RX_CLOCK_OPTION};
   qcrb_addr_t gl_ofs[4] = '{OFS_FIRMWARE_REVISION, OFS_PRESCALER_PERIOD,
                             OFS_RECEIVE_IRQ_CH, OFS_MODEM_IRQ_REQ};

   qcrb_bank i_qcrb_bank (.clk(clk), .rst_n(rst_n), .host_req(host_req), .rdata(rdata),
      .rvalid(rvalid), .service_active(service_active), .virt_in(virt_in),
      .sel_channel(sel_channel), .ch_dual_parallel(ch_dual_parallel),
      .tx_data_stb(tx_data_stb), .tx_data(tx_data), .end_service_stb(end_service_stb));
   qcrb_host #(.LANE_SHIFT(1), .BIG_END(1)) i_qcrb_host (.clk(clk), .host_req(host_req));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input qcrb_addr_t a, input qcrb_data_t d);
      i_qcrb_host.access(1'b0, a, d);
   endtask : wr

   // the note goes in before the strobe, so the monitor always finds it
   task automatic rd(input qcrb_addr_t a, input qcrb_data_t exp);
      rd_q.push_back(exp);
      i_qcrb_host.access(1'b1, a, 8'h00);
   endtask : rd

   task automatic settle();
      repeat (2) @(negedge clk);
   endtask : settle

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////////
   // monitor: rvalid stands one cycle, so it is looked at once per cycle
   always @(negedge clk) begin
      if (rst_n === 1'b1) begin
         if (rvalid === 1'b1) begin
            if (rd_q.size() == 0) chk("rvalid_unasked", 8'h00, 8'h01);
            else chk("rdata", rd_q.pop_front(), rdata);
         end
         if (tx_data_stb === 1'b1) begin
            if (tx_q.size() == 0) chk("tx_data_stb_unasked", 8'h00, 8'h01);
            else chk("tx_data", tx_q.pop_front(), tx_data);
         end
         if (end_service_stb === 1'b1) es_seen++;
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n          = 1'b0;
      service_active = 1'b0;
      virt_in        = '0;
      void'($urandom(32'h849fd6a7));
      do_reset();
      chk("sel_channel", 8'(RESET_CHANNEL), 8'(sel_channel));
      rd(OFS_CHANNEL_SELECT, 8'h00);
      // fill every bank, upper select bits random and ignored
      for (int c = 0; c < NUM_CH; c++) begin
         wr(OFS_CHANNEL_SELECT, {6'($urandom), 2'(c)});
         for (int k = 0; k < 3; k++) begin
            v[c][k] = 8'($urandom);
            wr(pc_ofs[k], v[c][k]);
         end
      end
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         wr(OFS_CHANNEL_SELECT, 8'(c));
         settle();
         chk("sel_channel", 8'(c), 8'(sel_channel));
         rd(OFS_CHANNEL_SELECT, 8'(c));
         for (int r = 0; r < 2; r++)
            for (int k = 0; k < 3; k++) rd(pc_ofs[k], v[c][k]);
      end
      // globals written under bank 2, read under bank 1
      wr(OFS_CHANNEL_SELECT, 8'h02);
      for (int k = 0; k < 4; k++) begin
         g[k] = 8'($urandom);
         wr(gl_ofs[k], g[k]);
      end
      wr(OFS_CHANNEL_SELECT, 8'h01);
      for (int k = 0; k < 4; k++) rd(gl_ofs[k], g[k]);
      // dual-function mode follows channel 0 only
      wr(OFS_GLOBAL_CONFIG, 8'h80);
      wr(OFS_CHANNEL_SELECT, 8'h00);
      settle();
      chk("ch_dual_parallel", 8'h01, 8'(ch_dual_parallel));
      for (int c = 1; c < NUM_CH; c++) begin
         wr(OFS_CHANNEL_SELECT, 8'(c));
         settle();
         chk("ch_dual_parallel", 8'h00, 8'(ch_dual_parallel));
      end
      rd(OFS_GLOBAL_CONFIG, 8'h80);
      // unmapped offsets and a read-only write
      wr(7'h30, 8'h5a);
      rd(7'h30, 8'h00);
      rd(7'h00, 8'h00);
      rd(7'h7f, 8'h00);
      virt_in = {$urandom, 16'($urandom)};
      wr(OFS_SERVICE_SUMMARY, ~virt_in.summary);
      rd(OFS_SERVICE_SUMMARY, virt_in.summary);
      // virtual registers outside and inside a service routine
      rd(OFS_RECEIVE_IRQ_VEC, VIRT_IDLE_BYTE);
      rd(OFS_RECEIVE_DATA_STAT, VIRT_IDLE_BYTE);
      wr(OFS_TRANSMIT_DATA, 8'h3c);
      wr(OFS_END_OF_SERVICE, 8'h00);
      @(negedge clk) service_active = 1'b1;
      rd(OFS_RECEIVE_IRQ_VEC, virt_in.rx_vector);
      rd(OFS_TRANSMIT_IRQ_VEC, virt_in.tx_vector);
      rd(OFS_MODEM_IRQ_VECTOR, virt_in.modem_vector);
      rd(OFS_RECEIVE_DATA_STAT, virt_in.rx_data);
      rd(OFS_MODEM_IRQ_STATUS, virt_in.modem_status);
      tx_q.push_back(8'hc3);
      wr(OFS_TRANSMIT_DATA, 8'hc3);
      es_exp++;
      wr(OFS_END_OF_SERVICE, 8'h00);
      @(negedge clk) service_active = 1'b0;
      // a second reset in mid-run lands back on channel 0
      wr(OFS_CHANNEL_SELECT, 8'h03);
      settle();
      do_reset();
      chk("sel_channel", 8'(RESET_CHANNEL), 8'(sel_channel));
      rd(OFS_CHANNEL_SELECT, 8'h00);
      rd(OFS_CHANNEL_OPTION_1, v[0][0]);
      repeat (4) @(negedge clk);
      chk("reads_left", 8'h00, 8'(rd_q.size()));
      chk("tx_left", 8'h00, 8'(tx_q.size()));
      chk("end_service_stb", 8'(es_exp), 8'(es_seen));
      close_out();
   end
endmodule : tb_qcrb_bank
`default_nettype wire
